// *** arc_readback_comparators.sv ***
// Auxiliary converter result registers, channel setup and threshold comparator one
// Summary of operation
// - Channel divider field bits 14:13, reset 11; off, /1, /2, /4.
// - Channel three reference bit 12, reset 1; 0 rtc supply, 1 bandgap.
// - Channel four has its own reference bit 12, independent of channel three.
// - Channel results are 12 bits in 11:0, reset zero, full scale equals reference.
// - Latest USB supply measurement readable in bits 11:0, reset zero.
// - Latest line supply measurement readable in bits 11:0, reset zero.
// - Latest battery measurement readable in bits 11:0, reset zero.
// - Latest die temperature measurement readable in bits 11:0, reset zero.
// - Comparator enables in bits 3:0, reset off, also cleared by power sequencer.
// - Source select bits 15:13 chooses one of eight results, reset 000.
// - Direction bit 12: 0 trips below threshold, 1 trips above.
// - Threshold is 12-bit unsigned in 11:0, compared with the selected result.
// - With hold option set, channel three, four, USB, line, battery or temperature waits until its result is read; channels one and two never wait.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "arc_defines.svh"

module arc_readback_comparators
  import arc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [`ARC_ADDR_W-1:0] regAddr,
  input wire logic [`ARC_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`ARC_DATA_W-1:0] regRdData,
  input wire logic resultValid,
  input wire logic [2:0] resultSource,
  input wire logic [`ARC_RES_W-1:0] resultData,
  output logic [7:0] sourceHold,
  input wire logic seqClear,
  output logic [1:0] chan3DividerSel,
  output logic chan3RefSel,
  output logic [1:0] chan4DividerSel,
  output logic chan4RefSel,
  output logic [3:0] cmpOn,
  output logic irq
);

  logic [`ARC_RES_W-1:0] chan3Result;
  logic [`ARC_RES_W-1:0] chan4Result;
  logic [`ARC_RES_W-1:0] usbSupplyValue;
  logic [`ARC_RES_W-1:0] lineSupplyValue;
  logic [`ARC_RES_W-1:0] batteryValue;
  logic [`ARC_RES_W-1:0] dieTempValue;
  arc_source_t cmp1Source;
  logic cmp1Direction;
  logic [`ARC_RES_W-1:0] cmp1Threshold;
  logic holdUntilRead;
  logic [7:0] unread;
  logic [`ARC_IRQ_W-1:0] irqStatus;
  logic [`ARC_IRQ_W-1:0] irqMask;
  logic [`ARC_IRQ_W-1:0] irqEvent;
  logic [`ARC_IRQ_W-1:0] irqClear;
  logic resultTaken;
  logic resultDropped;
  logic cmpTrip;
  logic [7:0] readHit;
  logic wrChan3;
  logic wrChan4;

  assign wrChan3 = regWrite && (regAddr == `ARC_ADDR_CHAN3);
  assign wrChan4 = regWrite && (regAddr == `ARC_ADDR_CHAN4);

  // Channels one and two keep their results elsewhere, so they are never held here
  assign sourceHold = {8{holdUntilRead}} & unread;
  assign resultTaken = resultValid && !sourceHold[resultSource];
  assign resultDropped = resultValid && sourceHold[resultSource];

  // Channel setup: divider and reference fields only, results stay untouched
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan3DividerSel <= `ARC_DIV_RESET;
      chan3RefSel <= `ARC_REF_RESET;
      chan4DividerSel <= `ARC_DIV_RESET;
      chan4RefSel <= `ARC_REF_RESET;
    end else begin
      if (wrChan3) begin
        chan3DividerSel <= regWrData[`ARC_DIV_HI:`ARC_DIV_LO];
        chan3RefSel <= regWrData[`ARC_REF_BIT];
      end
      if (wrChan4) begin
        chan4DividerSel <= regWrData[`ARC_DIV_HI:`ARC_DIV_LO];
        chan4RefSel <= regWrData[`ARC_REF_BIT];
      end
    end
  end

  // Result capture from the converter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan3Result <= `ARC_RES_RESET;
      chan4Result <= `ARC_RES_RESET;
      usbSupplyValue <= `ARC_RES_RESET;
      lineSupplyValue <= `ARC_RES_RESET;
      batteryValue <= `ARC_RES_RESET;
      dieTempValue <= `ARC_RES_RESET;
    end else if (resultTaken) begin
      case (arc_source_t'(resultSource))
        ARC_SRC_CHAN3: chan3Result <= resultData;
        ARC_SRC_CHAN4: chan4Result <= resultData;
        ARC_SRC_USB: usbSupplyValue <= resultData;
        ARC_SRC_LINE: lineSupplyValue <= resultData;
        ARC_SRC_BATT: batteryValue <= resultData;
        ARC_SRC_TEMP: dieTempValue <= resultData;
        default: ;
      endcase
    end
  end

  always_comb begin
    readHit = 8'h00;
    if (regRead) begin
      readHit[ARC_SRC_CHAN3] = (regAddr == `ARC_ADDR_CHAN3);
      readHit[ARC_SRC_CHAN4] = (regAddr == `ARC_ADDR_CHAN4);
      readHit[ARC_SRC_USB] = (regAddr == `ARC_ADDR_USB);
      readHit[ARC_SRC_LINE] = (regAddr == `ARC_ADDR_LINE);
      readHit[ARC_SRC_BATT] = (regAddr == `ARC_ADDR_BATT);
      readHit[ARC_SRC_TEMP] = (regAddr == `ARC_ADDR_TEMP);
    end
  end

  // Unread marks: a new result in the same cycle as a read leaves the mark set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      unread <= `ARC_UNREAD_RESET;
    end else begin
      for (int i = 2; i < 8; i++) begin
        if (resultTaken && (resultSource == 3'(i))) begin
          unread[i] <= 1'b1;
        end else if (readHit[i]) begin
          unread[i] <= 1'b0;
        end
      end
    end
  end

  // Comparator configuration; the sequencer clear hits only enables, source and hold
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmpOn <= `ARC_EN_RESET;
      cmp1Source <= arc_source_t'(`ARC_SRC_RESET);
      holdUntilRead <= `ARC_HOLD_RESET;
    end else if (seqClear) begin
      cmpOn <= `ARC_EN_RESET;
      cmp1Source <= arc_source_t'(`ARC_SRC_RESET);
      holdUntilRead <= `ARC_HOLD_RESET;
    end else if (regWrite) begin
      if (regAddr == `ARC_ADDR_CMPEN) begin
        cmpOn <= regWrData[`ARC_EN_HI:`ARC_EN_LO];
      end
      if (regAddr == `ARC_ADDR_CMP1) begin
        cmp1Source <= arc_source_t'(regWrData[`ARC_SRC_HI:`ARC_SRC_LO]);
      end
      if (regAddr == `ARC_ADDR_OPTIONS) begin
        holdUntilRead <= regWrData[`ARC_HOLD_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp1Direction <= `ARC_DIR_RESET;
      cmp1Threshold <= `ARC_THR_RESET;
    end else if (regWrite && (regAddr == `ARC_ADDR_CMP1)) begin
      cmp1Direction <= regWrData[`ARC_DIR_BIT];
      cmp1Threshold <= regWrData[`ARC_THR_HI:`ARC_THR_LO];
    end
  end

  // Evaluated on the arriving value, which is what the source register takes this edge
  always_comb begin
    cmpTrip = 1'b0;
    if (cmpOn[0] && resultTaken && (resultSource == cmp1Source)) begin
      if (cmp1Direction) begin
        cmpTrip = resultData > cmp1Threshold;
      end else begin
        cmpTrip = resultData < cmp1Threshold;
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over a clear
  always_comb begin
    irqEvent = `ARC_IRQ_RESET;
    irqEvent[`ARC_IRQ_CMP1] = cmpTrip;
    irqEvent[`ARC_IRQ_DROP] = resultDropped;
    irqClear = `ARC_IRQ_RESET;
    if (regWrite && (regAddr == `ARC_ADDR_IRQSTAT)) begin
      irqClear = regWrData[`ARC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqStatus <= `ARC_IRQ_RESET;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvent;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqMask <= `ARC_IRQ_RESET;
    end else if (regWrite && (regAddr == `ARC_ADDR_IRQMASK)) begin
      irqMask <= regWrData[`ARC_IRQ_W-1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // Read data stand for exactly one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData <= '0;
    end else if (!regRead) begin
      regRdData <= '0;
    end else begin
      case (regAddr)
        `ARC_ADDR_CHAN3: regRdData <= {1'b0, chan3DividerSel, chan3RefSel, chan3Result};
        `ARC_ADDR_CHAN4: regRdData <= {1'b0, chan4DividerSel, chan4RefSel, chan4Result};
        `ARC_ADDR_USB: regRdData <= {4'h0, usbSupplyValue};
        `ARC_ADDR_LINE: regRdData <= {4'h0, lineSupplyValue};
        `ARC_ADDR_BATT: regRdData <= {4'h0, batteryValue};
        `ARC_ADDR_TEMP: regRdData <= {4'h0, dieTempValue};
        `ARC_ADDR_CMPEN: regRdData <= {12'h000, cmpOn};
        `ARC_ADDR_CMP1: regRdData <= {cmp1Source, cmp1Direction, cmp1Threshold};
        `ARC_ADDR_IRQSTAT: regRdData <= {14'h0000, irqStatus};
        `ARC_ADDR_IRQMASK: regRdData <= {14'h0000, irqMask};
        `ARC_ADDR_OPTIONS: regRdData <= {15'h0000, holdUntilRead};
        default: regRdData <= '0;
      endcase
    end
  end

  a_divider_write: assert property (@(posedge clk) disable iff (reset)
    wrChan3 |=> chan3DividerSel == $past(regWrData[`ARC_DIV_HI:`ARC_DIV_LO]))
    else $error("Channel three divider did not take the written value");

  a_chan3_ref: assert property (@(posedge clk) disable iff (reset)
    wrChan3 |=> chan3RefSel == $past(regWrData[`ARC_REF_BIT]))
    else $error("Channel three reference did not take the written value");

  a_ref_independent: assert property (@(posedge clk) disable iff (reset)
    (wrChan4 && !wrChan3) |=> $stable(chan3RefSel) &&
      chan4RefSel == $past(regWrData[`ARC_REF_BIT]))
    else $error("Channel four reference write disturbed channel three");

  a_chan3_capture: assert property (@(posedge clk) disable iff (reset)
    (resultTaken && resultSource == ARC_SRC_CHAN3) |=> chan3Result == $past(resultData))
    else $error("Channel three result not captured");

  a_usb_capture: assert property (@(posedge clk) disable iff (reset)
    (resultTaken && resultSource == ARC_SRC_USB) ##1 !resultValid ##1
      (regRead && regAddr == `ARC_ADDR_USB) |=>
      regRdData[`ARC_RES_HI:`ARC_RES_LO] == $past(resultData, 3))
    else $error("USB supply readback wrong");

  a_line_capture: assert property (@(posedge clk) disable iff (reset)
    (resultTaken && resultSource == ARC_SRC_LINE) |=> lineSupplyValue == $past(resultData))
    else $error("Line supply result not captured");

  a_batt_capture: assert property (@(posedge clk) disable iff (reset)
    (resultTaken && resultSource == ARC_SRC_BATT) |=> batteryValue == $past(resultData))
    else $error("Battery result not captured");

  a_temp_read: assert property (@(posedge clk) disable iff (reset)
    (regRead && regAddr == `ARC_ADDR_TEMP && !resultValid) |=>
      regRdData == {4'h0, dieTempValue})
    else $error("Die temperature readback wrong");

  a_seq_clear: assert property (@(posedge clk) disable iff (reset)
    seqClear |=> cmpOn == 4'h0 && cmp1Source == ARC_SRC_CHAN1)
    else $error("Sequencer clear left comparator enabled or sourced");

  a_source_write: assert property (@(posedge clk) disable iff (reset)
    (regWrite && regAddr == `ARC_ADDR_CMP1 && !seqClear) |=>
      cmp1Source == $past(regWrData[`ARC_SRC_HI:`ARC_SRC_LO]))
    else $error("Comparator source not written");

  a_below_trip: assert property (@(posedge clk) disable iff (reset)
    (cmpOn[0] && resultTaken && resultSource == cmp1Source && !cmp1Direction &&
      resultData < cmp1Threshold) |=> irqStatus[`ARC_IRQ_CMP1])
    else $error("Below-threshold trip not flagged");

  a_above_trip: assert property (@(posedge clk) disable iff (reset)
    (cmpOn[0] && resultTaken && resultSource == cmp1Source && cmp1Direction &&
      resultData > cmp1Threshold) |=> irqStatus[`ARC_IRQ_CMP1])
    else $error("Above-threshold trip not flagged");

  a_hold_block: assert property (@(posedge clk) disable iff (reset)
    (resultValid && resultSource == ARC_SRC_BATT && holdUntilRead && unread[ARC_SRC_BATT]) |=>
      $stable(batteryValue) && irqStatus[`ARC_IRQ_DROP])
    else $error("Held channel overwritten");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (reset)
    !cmpOn[0] |-> !cmpTrip)
    else $error("Disabled comparator tripped");

  a_result_ro: assert property (@(posedge clk) disable iff (reset)
    (wrChan4 && !resultValid) |=> $stable(chan4Result))
    else $error("Register write changed a result");

  // Writes, captures and status bits seen from the register side
  a_chan4_divider: assert property (@(posedge clk) disable iff (reset)
    wrChan4 |=> chan4DividerSel == $past(regWrData[`ARC_DIV_HI:`ARC_DIV_LO]))
    else $error("Channel four divider did not take the written value");

  a_chan4_keep: assert property (@(posedge clk) disable iff (reset)
    (wrChan3 && !wrChan4) |=> $stable(chan4RefSel))
    else $error("Channel three reference write disturbed channel four");

  a_chan4_capture: assert property (@(posedge clk) disable iff (reset)
    (resultTaken && resultSource == ARC_SRC_CHAN4) |=> chan4Result == $past(resultData))
    else $error("Channel four result not captured");

  a_usb_value: assert property (@(posedge clk) disable iff (reset)
    (resultTaken && resultSource == ARC_SRC_USB) |=> usbSupplyValue == $past(resultData))
    else $error("USB supply result not captured");

  a_temp_capture: assert property (@(posedge clk) disable iff (reset)
    (resultTaken && resultSource == ARC_SRC_TEMP) |=> dieTempValue == $past(resultData))
    else $error("Die temperature result not captured");

  a_enable_write: assert property (@(posedge clk) disable iff (reset)
    (regWrite && regAddr == `ARC_ADDR_CMPEN && !seqClear) |=>
      cmpOn == $past(regWrData[`ARC_EN_HI:`ARC_EN_LO]))
    else $error("Comparator enables not written");

  a_direction_write: assert property (@(posedge clk) disable iff (reset)
    (regWrite && regAddr == `ARC_ADDR_CMP1) |=>
      cmp1Direction == $past(regWrData[`ARC_DIR_BIT]))
    else $error("Comparator direction not written");

  a_threshold_write: assert property (@(posedge clk) disable iff (reset)
    (regWrite && regAddr == `ARC_ADDR_CMP1) |=>
      cmp1Threshold == $past(regWrData[`ARC_THR_HI:`ARC_THR_LO]))
    else $error("Comparator threshold not written");

  a_seq_keep_thr: assert property (@(posedge clk) disable iff (reset)
    (seqClear && !regWrite) |=> $stable({cmp1Direction, cmp1Threshold}))
    else $error("Sequencer clear changed direction or threshold");

  a_trip_cause: assert property (@(posedge clk) disable iff (reset)
    !irqStatus[`ARC_IRQ_CMP1] ##1 irqStatus[`ARC_IRQ_CMP1] |->
      $past(cmpOn[0] && resultTaken && resultSource == cmp1Source &&
        (cmp1Direction ? resultData > cmp1Threshold : resultData < cmp1Threshold)))
    else $error("Comparator status set without a qualifying result");

  a_status_sticky: assert property (@(posedge clk) disable iff (reset)
    (irqStatus[`ARC_IRQ_CMP1] && !irqClear[`ARC_IRQ_CMP1]) |=> irqStatus[`ARC_IRQ_CMP1])
    else $error("Comparator status lost without a clear");

  a_chan3_result_ro: assert property (@(posedge clk) disable iff (reset)
    (wrChan3 && !resultValid) |=> $stable(chan3Result))
    else $error("Register write changed channel three result");

  a_fixed_ro: assert property (@(posedge clk) disable iff (reset)
    (regWrite && !resultValid) |=>
      $stable({usbSupplyValue, lineSupplyValue, batteryValue, dieTempValue}))
    else $error("Register write changed a supply or temperature result");

  a_seq_hold_off: assert property (@(posedge clk) disable iff (reset)
    seqClear |=> !holdUntilRead)
    else $error("Sequencer clear left the hold option set");

  a_hold_release: assert property (@(posedge clk) disable iff (reset)
    (regRead && regAddr == `ARC_ADDR_BATT &&
      !(resultTaken && resultSource == ARC_SRC_BATT)) |=> !unread[ARC_SRC_BATT])
    else $error("Reading the battery result left it marked unread");

  a_drop_flag: assert property (@(posedge clk) disable iff (reset)
    resultDropped |=> irqStatus[`ARC_IRQ_DROP])
    else $error("Dropped result not flagged");

endmodule : arc_readback_comparators

// *** arc_defines.svh ***
// Offsets, field positions and reset values of the readback and comparator registers
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

`define ARC_ADDR_W 8
`define ARC_DATA_W 16
`define ARC_RES_W 12

`define ARC_ADDR_CHAN3 8'h9a
`define ARC_ADDR_CHAN4 8'h9b
`define ARC_ADDR_USB 8'h9c
`define ARC_ADDR_LINE 8'h9d
`define ARC_ADDR_BATT 8'h9e
`define ARC_ADDR_TEMP 8'h9f
`define ARC_ADDR_CMPEN 8'ha3
`define ARC_ADDR_CMP1 8'ha4
`define ARC_ADDR_IRQSTAT 8'he0
`define ARC_ADDR_IRQMASK 8'he1
`define ARC_ADDR_OPTIONS 8'he2

`define ARC_DIV_HI 14
`define ARC_DIV_LO 13
`define ARC_REF_BIT 12
`define ARC_RES_HI 11
`define ARC_RES_LO 0
`define ARC_SRC_HI 15
`define ARC_SRC_LO 13
`define ARC_DIR_BIT 12
`define ARC_THR_HI 11
`define ARC_THR_LO 0
`define ARC_EN_HI 3
`define ARC_EN_LO 0
`define ARC_HOLD_BIT 0

`define ARC_DIV_RESET 2'h3
`define ARC_REF_RESET 1'h1
`define ARC_RES_RESET 12'h000
`define ARC_EN_RESET 4'h0
`define ARC_SRC_RESET 3'h0
`define ARC_DIR_RESET 1'h0
`define ARC_THR_RESET 12'h000
`define ARC_IRQ_W 2
`define ARC_IRQ_CMP1 0
`define ARC_IRQ_DROP 1
`define ARC_IRQ_RESET 2'h0
`define ARC_HOLD_RESET 1'h0
`define ARC_UNREAD_RESET 8'h00

`endif

// *** arc_pkg.sv ***
// Types shared by the auxiliary converter readback block
package arc_pkg;
  typedef enum logic [2:0] {
    ARC_SRC_CHAN1 = 3'h0,
    ARC_SRC_CHAN2 = 3'h1,
    ARC_SRC_CHAN3 = 3'h2,
    ARC_SRC_CHAN4 = 3'h3,
    ARC_SRC_USB = 3'h4,
    ARC_SRC_LINE = 3'h5,
    ARC_SRC_BATT = 3'h6,
    ARC_SRC_TEMP = 3'h7
  } arc_source_t;

  typedef enum logic [1:0] {
    ARC_DIV_OFF = 2'h0,
    ARC_DIV_BY1 = 2'h1,
    ARC_DIV_BY2 = 2'h2,
    ARC_DIV_BY4 = 2'h3
  } arc_divider_t;
endpackage : arc_pkg

// *** test_arc_readback_comparators.sv ***
// Self-checking testbench for the readback and comparator register block
`timescale 1ns/1ns
`include "arc_defines.svh"

module test_arc_readback_comparators
  import arc_pkg::*;
;
  logic clk;
  logic reset;
  logic [7:0] regAddr;
  logic [15:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [15:0] regRdData;
  logic resultValid;
  logic [2:0] resultSource;
  logic [11:0] resultData;
  logic [7:0] sourceHold;
  logic seqClear;
  logic [1:0] chan3DividerSel;
  logic chan3RefSel;
  logic [1:0] chan4DividerSel;
  logic chan4RefSel;
  logic [3:0] cmpOn;
  logic irq;
  int errTotal = 0;
  int compares = 0;

  arc_readback_comparators i_arc_readback_comparators (
    .clk(clk),
    .reset(reset),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .resultValid(resultValid),
    .resultSource(resultSource),
    .resultData(resultData),
    .sourceHold(sourceHold),
    .seqClear(seqClear),
    .chan3DividerSel(chan3DividerSel),
    .chan3RefSel(chan3RefSel),
    .chan4DividerSel(chan4DividerSel),
    .chan4RefSel(chan4RefSel),
    .cmpOn(cmpOn),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Each task ends 1 ns after the edge that took the request, so updates have landed
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the taking edge
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, exp, what);
  endtask : rdChk

  task automatic res(input logic [2:0] s, input logic [11:0] d);
    @(posedge clk);
    resultValid <= 1'b1;
    resultSource <= s;
    resultData <= d;
    @(posedge clk);
    resultValid <= 1'b0;
    #1;
  endtask : res

  task automatic testReset;
    rdChk(`ARC_ADDR_CHAN3, 16'h7000, "chan3 reset");
    rdChk(`ARC_ADDR_CHAN4, 16'h7000, "chan4 reset");
    for (int a = 8'h9c; a <= 8'h9f; a++) begin
      rdChk(8'(a), 16'h0000, "fixed result reset");
    end
    rdChk(`ARC_ADDR_CMPEN, 16'h0000, "enables reset");
    rdChk(`ARC_ADDR_CMP1, 16'h0000, "cmp1 reset");
    rdChk(8'h80, 16'h0000, "unmapped read");
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0000, "status reset");
    rdChk(`ARC_ADDR_IRQMASK, 16'h0000, "mask reset");
    rdChk(`ARC_ADDR_OPTIONS, 16'h0000, "option reset");
    chk({9'h0, chan3DividerSel, chan3RefSel, chan4DividerSel, chan4RefSel, irq},
        16'h007e, "setup outputs reset");
    chk({4'h0, cmpOn, sourceHold}, 16'h0000, "enables and hold reset");
    $display("test reset done");
  endtask : testReset

  task automatic testResults;
    logic [11:0] v;
    // Source s lands at 98h + s; source 7 gets full scale
    for (int s = 2; s <= 7; s++) begin
      v = 12'(12'h249 * s);
      res(3'(s), v);
      rdChk(8'(8'h98 + s), (s < 4) ? {4'h7, v} : {4'h0, v},
            "result readback");
    end
    wr(`ARC_ADDR_CHAN3, 16'h2fff);
    wr(`ARC_ADDR_CHAN4, 16'h5000);
    wr(`ARC_ADDR_USB, 16'hffff);
    rdChk(`ARC_ADDR_CHAN3, 16'h2492, "chan3 after write");
    rdChk(`ARC_ADDR_CHAN4, 16'h56db, "chan4 after write");
    rdChk(`ARC_ADDR_USB, 16'h0924, "usb after write");
    chk({9'h0, chan3DividerSel, chan3RefSel, chan4DividerSel, chan4RefSel, irq},
        16'h002a, "independent references");
    for (int d = 0; d < 4; d++) begin
      wr(`ARC_ADDR_CHAN3, {1'b0, 2'(d), 1'b1, 12'h000});
      chk({14'h0, chan3DividerSel}, 16'(d), "divider code");
    end
    $display("test results done");
  endtask : testResults

  task automatic testCompare;
    wr(`ARC_ADDR_IRQMASK, 16'h0001);
    wr(`ARC_ADDR_CMP1, 16'hc800);
    res(3'h6, 12'h7ff);
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0000, "disabled no trip");
    wr(`ARC_ADDR_CMPEN, 16'h0001);
    chk({12'h0, cmpOn}, 16'h0001, "enable output");
    res(3'h6, 12'h800);
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0000, "equal no trip");
    res(3'h5, 12'h7ff);
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0000, "other source no trip");
    res(3'h6, 12'h7ff);
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0001, "below trips");
    chk({15'h0, irq}, 16'h0001, "irq raised");
    wr(`ARC_ADDR_IRQSTAT, 16'h0001);
    chk({15'h0, irq}, 16'h0000, "irq cleared");
    // Masked trip keeps status but holds the line low until unmasked
    wr(`ARC_ADDR_IRQMASK, 16'h0000);
    res(3'h6, 12'h7ff);
    chk({15'h0, irq}, 16'h0000, "irq masked");
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0001, "masked status");
    wr(`ARC_ADDR_IRQMASK, 16'h0001);
    chk({15'h0, irq}, 16'h0001, "irq unmasked");
    wr(`ARC_ADDR_IRQSTAT, 16'h0001);
    wr(`ARC_ADDR_CMP1, 16'hd800);
    rdChk(`ARC_ADDR_CMP1, 16'hd800, "cmp1 readback");
    res(3'h6, 12'h800);
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0000, "above equal no trip");
    res(3'h6, 12'h801);
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0001, "above trips");
    wr(`ARC_ADDR_IRQSTAT, 16'h0001);
    for (int s = 0; s < 8; s++) begin
      wr(`ARC_ADDR_CMP1, {3'(s), 1'b1, 12'h000});
      res(3'(s + 1), 12'hfff);
      rdChk(`ARC_ADDR_IRQSTAT, 16'h0000, "unselected source");
      res(3'(s), 12'h001);
      rdChk(`ARC_ADDR_IRQSTAT, 16'h0001, "selected source");
      wr(`ARC_ADDR_IRQSTAT, 16'h0001);
    end
    $display("test compare done");
  endtask : testCompare

  task automatic testSeqClear;
    wr(`ARC_ADDR_CMPEN, 16'h000f);
    chk({12'h0, cmpOn}, 16'h000f, "all enables");
    wr(`ARC_ADDR_OPTIONS, 16'h0001);
    wr(`ARC_ADDR_CMP1, 16'he123);
    @(posedge clk);
    seqClear <= 1'b1;
    @(posedge clk);
    seqClear <= 1'b0;
    #1;
    chk({12'h0, cmpOn}, 16'h0000, "sequencer clears enables");
    rdChk(`ARC_ADDR_CMPEN, 16'h0000, "enables read");
    rdChk(`ARC_ADDR_CMP1, 16'h0123, "source cleared");
    rdChk(`ARC_ADDR_OPTIONS, 16'h0000, "hold option cleared");
    $display("test sequencer clear done");
  endtask : testSeqClear

  task automatic testHold;
    // Earlier tests leave every stored source unread; clear the marks before holding
    rdChk(`ARC_ADDR_CHAN3, 16'h7001, "chan3 last result");
    rdChk(`ARC_ADDR_CHAN4, 16'h5001, "chan4 last result");
    for (int a = 8'h9c; a <= 8'h9f; a++) begin
      rdChk(8'(a), 16'h0001, "fixed last result");
    end
    wr(`ARC_ADDR_OPTIONS, 16'h0001);
    chk({8'h0, sourceHold}, 16'h0000, "hold idle after reads");
    wr(`ARC_ADDR_IRQMASK, 16'h0003);
    res(3'h6, 12'h123);
    chk({8'h0, sourceHold}, 16'h0040, "hold raised");
    res(3'h6, 12'h456);
    rdChk(`ARC_ADDR_IRQSTAT, 16'h0002, "dropped result");
    chk({15'h0, irq}, 16'h0001, "drop irq");
    rdChk(`ARC_ADDR_BATT, 16'h0123, "old result kept");
    chk({8'h0, sourceHold}, 16'h0000, "hold released by read");
    res(3'h6, 12'h456);
    rdChk(`ARC_ADDR_BATT, 16'h0456, "new result after read");
    wr(`ARC_ADDR_IRQSTAT, 16'h0002);
    wr(`ARC_ADDR_OPTIONS, 16'h0000);
    chk({15'h0, irq}, 16'h0000, "drop irq cleared");
    $display("test hold done");
  endtask : testHold

  task automatic testDone;
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : testDone

  // Watchdog: the sequence needs only about 250 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    testDone();
  end

  initial begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    resultValid = 1'b0;
    resultSource = 3'h0;
    resultData = 12'h000;
    seqClear = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    testReset();
    testResults();
    testCompare();
    testSeqClear();
    testHold();
    testDone();
  end
endmodule : test_arc_readback_comparators
